// [core/mpmc_top.v]
// Power-mode controller: decodes the two mode-select pins, sequences
// power through idle, gates pins, runs the current detector and the
// partial current estimator, and holds the register port.
// Assumes inputs synchronous to mclk and a one-cycle-read register port.
//
// Functional notes
// - Mode comes only from the two pins
// - Normal: all on, detector off
// - Idle: everything shut down, analog powered down
// - Idle: zero-cross, pulses, warning, interrupts low
// - Idle: serial pins become inputs
// - Idle: oscillator stopped, its output low
// - Idle: pins still watched for wake
// - Detection: comparators check each phase threshold
// - Detection: any phase over sets irq one
// - Detection: all phases over sets irq two
// - Detector latches cleared entering or leaving
// - Detection pins as idle, except interrupts and oscillator output
// - Per-phase positive and negative comparators, both default
// - Comparator powered by its control enable
// - Partial: voltage, neutral, digital off; one cycle RMS
// - Partial: done raises irq one until exit
// - Partial: only listed registers are accessible
// - Every mode change passes through idle
// - Estimator gives unsigned RMS or signed average
// - Estimator runs in partial and normal modes
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "mpmc_regs.vh"

module mpmc_top #(
  parameter integer OSC_WAIT_CYC = `MPMC_OSC_WAIT_US * `MPMC_CLK_MHZ,
  parameter integer FILT_CYC = `MPMC_PIN_FILT_US * `MPMC_CLK_MHZ,
  parameter integer WIN_LOG2 = 7
) (
  input wire mclk,
  input wire rst_n,
  input wire mode_select_high,
  input wire mode_select_low,
  input wire [9:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [47:0] cur_samples,
  input wire sample_valid,
  input wire [2:0] zx_src,
  input wire [3:0] pulse_src,
  input wire warn_src,
  input wire interrupt_out_first_src,
  input wire interrupt_out_second_src,
  input wire [3:0] spi_oe_src,
  input wire [3:0] spi_o_src,
  input wire crystal_in,
  output reg [2:0] zero_cross_out,
  output reg [3:0] energy_pulse_out,
  output reg warning_output,
  output reg interrupt_out_first,
  output reg interrupt_out_second,
  output reg [3:0] spi_oe,
  output reg [3:0] spi_o,
  output reg crystal_out,
  output reg osc_en,
  output reg pwr_analog_en,
  output reg pwr_volt_adc_en,
  output reg pwr_neutral_adc_en,
  output reg pwr_curr_adc_en,
  output reg pwr_digital_en,
  output reg [2:0] cmp_pos_en,
  output reg [2:0] cmp_neg_en
);

  // ----------------------------------------------------------------
  // Mode pin synchroniser and filter
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAKE = 3'h1;
  localparam [2:0] ST_NORM = 3'h2;
  localparam [2:0] ST_PART = 3'h3;
  localparam [2:0] ST_DET = 3'h4;

  reg [1:0] pin_s1_q;
  reg [1:0] pin_s2_q;
  reg [1:0] pin_cand_q;
  reg [1:0] pin_mode_q;
  reg [15:0] filt_cnt_q;

  // Long filter only costs mode-change latency; a glitch shorter than it is dropped
  always @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_cand_q <= 2'h0;
      pin_mode_q <= `MPMC_PINS_IDLE;
      filt_cnt_q <= 16'h0000;
    end else begin
      pin_s1_q <= {mode_select_high, mode_select_low};
      pin_s2_q <= pin_s1_q;
      if (pin_s2_q != pin_cand_q) begin
        pin_cand_q <= pin_s2_q;
        filt_cnt_q <= 16'h0000;
      end else if (filt_cnt_q == FILT_CYC[15:0] - 16'h0001) begin
        pin_mode_q <= pin_cand_q;
      end else begin
        filt_cnt_q <= filt_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-mode state machine
  // ----------------------------------------------------------------
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [31:0] wake_cnt_q;

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (pin_mode_q != `MPMC_PINS_IDLE) begin
          st_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (pin_mode_q == `MPMC_PINS_IDLE) begin
          st_d = ST_IDLE;
        end else if (wake_cnt_q >= OSC_WAIT_CYC - 1) begin
          case (pin_mode_q)
            `MPMC_PINS_NORMAL: st_d = ST_NORM;
            `MPMC_PINS_PARTIAL: st_d = ST_PART;
            default: st_d = ST_DET;
          endcase
        end
      end
      ST_NORM: begin
        if (pin_mode_q != `MPMC_PINS_NORMAL) begin
          st_d = ST_IDLE;
        end
      end
      ST_PART: begin
        if (pin_mode_q != `MPMC_PINS_PARTIAL) begin
          st_d = ST_IDLE;
        end
      end
      ST_DET: begin
        if (pin_mode_q != `MPMC_PINS_DETECT) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      wake_cnt_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      if (st_q == ST_WAKE) begin
        wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
      end else begin
        wake_cnt_q <= 32'h0000_0000;
      end
    end
  end

  wire in_norm = (st_q == ST_NORM);
  wire in_part = (st_q == ST_PART);
  wire in_det = (st_q == ST_DET);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [5:0] det_ctrl_q;
  reg pm_avg_q;
  reg [15:0] thr_q [0:5];
  wire [15:0] res_w [0:2];
  reg det_interrupt_out_first_q;
  reg det_interrupt_out_second_q;
  reg part_done_q;

  // Outside the listed window and offsets a partial-mode access is dropped silently
  wire part_ok = ((reg_addr >= `MPMC_PART_LO) && (reg_addr <= `MPMC_PART_HI)) ||
    (reg_addr == `MPMC_SPEC_0) || (reg_addr == `MPMC_SPEC_1) || (reg_addr == `MPMC_SPEC_3) ||
    (reg_addr == `MPMC_SPEC_7) || (reg_addr == `MPMC_SPEC_E) || (reg_addr == `MPMC_SPEC_F);
  wire acc_ok = in_norm || (in_part && part_ok);
  wire wr_ok = reg_wr && acc_ok;
  wire [9:0] thr_idx = reg_addr - `MPMC_REG_THR_POS_A;

  integer k;
  always @(posedge mclk) begin
    if (!rst_n) begin
      det_ctrl_q <= `MPMC_DET_CTRL_RST;
      pm_avg_q <= `MPMC_PM_CFG_RST;
      for (k = 0; k < 6; k = k + 1) begin
        thr_q[k] <= `MPMC_THR_RST;
      end
    end else if (wr_ok) begin
      if (reg_addr == `MPMC_REG_DET_CTRL) begin
        det_ctrl_q <= reg_wdata[5:0];
      end else if (reg_addr == `MPMC_REG_PM_CFG) begin
        pm_avg_q <= reg_wdata[`MPMC_PM_CFG_AVG_BIT];
      end else if ((reg_addr >= `MPMC_REG_THR_POS_A) && (thr_idx < 10'h006)) begin
        thr_q[thr_idx[2:0]] <= reg_wdata;
      end
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && acc_ok) begin
      if (reg_addr == `MPMC_REG_STATUS) begin
        reg_rdata <= {10'h000, part_done_q, det_interrupt_out_second_q, det_interrupt_out_first_q, st_q};
      end else if (reg_addr == `MPMC_REG_DET_CTRL) begin
        reg_rdata <= {10'h000, det_ctrl_q};
      end else if (reg_addr == `MPMC_REG_PM_CFG) begin
        reg_rdata <= {15'h0000, pm_avg_q};
      end else if (reg_addr == `MPMC_REG_RES_A) begin
        reg_rdata <= res_w[0];
      end else if (reg_addr == `MPMC_REG_RES_B) begin
        reg_rdata <= res_w[1];
      end else if (reg_addr == `MPMC_REG_RES_C) begin
        reg_rdata <= res_w[2];
      end else if ((reg_addr >= `MPMC_REG_THR_POS_A) && (thr_idx < 10'h006)) begin
        reg_rdata <= thr_q[thr_idx[2:0]];
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Current detector and partial current estimator, per phase
  // ----------------------------------------------------------------
  function [15:0] isqrt;
    input [31:0] v;
    reg [15:0] q;
    reg [15:0] t;
    integer i;
    begin
      q = 16'h0000;
      for (i = 15; i >= 0; i = i - 1) begin
        t = q | (16'h0001 << i);
        if (({16'h0000, t} * {16'h0000, t}) <= v) begin
          q = t;
        end
      end
      isqrt = q;
    end
  endfunction

  wire est_run = in_norm || in_part;
  reg [WIN_LOG2-1:0] win_cnt_q;
  wire win_end = sample_valid && (&win_cnt_q);
  wire [2:0] ph_hit;

  always @(posedge mclk) begin
    if (!rst_n || !est_run) begin
      win_cnt_q <= {WIN_LOG2{1'b0}};
    end else if (sample_valid) begin
      win_cnt_q <= win_cnt_q + 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      wire signed [15:0] smp = cur_samples[16*g+15:16*g];
      wire signed [16:0] neg_thr = -$signed({1'b0, thr_q[g+3]});
      wire pos_hit = det_ctrl_q[`MPMC_DET_POS_LSB+g] && (smp > $signed({1'b0, thr_q[g]}));
      wire neg_hit = det_ctrl_q[`MPMC_DET_NEG_LSB+g] && ($signed({smp[15], smp}) < neg_thr);
      reg [31+WIN_LOG2:0] sq_acc_q;
      reg signed [15+WIN_LOG2:0] dc_acc_q;
      reg [15:0] res_q;
      wire [31:0] sq = smp * smp;
      wire [31+WIN_LOG2:0] sq_sum = sq_acc_q + {{WIN_LOG2{1'b0}}, sq};
      wire signed [15+WIN_LOG2:0] dc_sum = dc_acc_q + {{WIN_LOG2{smp[15]}}, smp};

      assign ph_hit[g] = in_det && (pos_hit || neg_hit);
      assign res_w[g] = res_q;

      always @(posedge mclk) begin
        if (!rst_n || !est_run) begin
          sq_acc_q <= {(32+WIN_LOG2){1'b0}};
          dc_acc_q <= {(16+WIN_LOG2){1'b0}};
          if (!rst_n) begin
            res_q <= 16'h0000;
          end
        end else if (win_end) begin
          sq_acc_q <= {(32+WIN_LOG2){1'b0}};
          dc_acc_q <= {(16+WIN_LOG2){1'b0}};
          // Signed average or unsigned root of the window mean square
          res_q <= pm_avg_q ? dc_sum[15+WIN_LOG2:WIN_LOG2] : isqrt(sq_sum[31+WIN_LOG2:WIN_LOG2]);
        end else if (sample_valid) begin
          sq_acc_q <= sq_sum;
          dc_acc_q <= dc_sum;
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (!rst_n || !in_det) begin
      det_interrupt_out_first_q <= 1'b0;
      det_interrupt_out_second_q <= 1'b0;
    end else begin
      if (|ph_hit) begin
        det_interrupt_out_first_q <= 1'b1;
      end
      if (&ph_hit) begin
        det_interrupt_out_second_q <= 1'b1;
      end
    end
  end

  always @(posedge mclk) begin
    if (!rst_n || !in_part) begin
      part_done_q <= 1'b0;
    end else if (win_end) begin
      part_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin states and power enables
  // ----------------------------------------------------------------
  wire osc_run = (st_q != ST_IDLE);
  wire serial_on = in_norm || in_part;

  always @(posedge mclk) begin
    if (!rst_n) begin
      zero_cross_out <= 3'h0;
      energy_pulse_out <= 4'h0;
      warning_output <= 1'b0;
      interrupt_out_first <= 1'b0;
      interrupt_out_second <= 1'b0;
      spi_oe <= 4'h0;
      spi_o <= 4'h0;
      crystal_out <= 1'b0;
      osc_en <= 1'b0;
      pwr_analog_en <= 1'b0;
      pwr_volt_adc_en <= 1'b0;
      pwr_neutral_adc_en <= 1'b0;
      pwr_curr_adc_en <= 1'b0;
      pwr_digital_en <= 1'b0;
      cmp_pos_en <= 3'h0;
      cmp_neg_en <= 3'h0;
    end else begin
      zero_cross_out <= in_norm ? zx_src : 3'h0;
      energy_pulse_out <= in_norm ? pulse_src : 4'h0;
      warning_output <= in_norm & warn_src;
      // Interrupts keep working in detection mode only as detector flags
      interrupt_out_first <= (in_norm & interrupt_out_first_src) | (in_part & part_done_q) | (in_det & det_interrupt_out_first_q);
      interrupt_out_second <= (in_norm & interrupt_out_second_src) | (in_det & det_interrupt_out_second_q);
      spi_oe <= serial_on ? spi_oe_src : 4'h0;
      spi_o <= serial_on ? spi_o_src : 4'h0;
      crystal_out <= osc_run & crystal_in;
      osc_en <= osc_run;
      pwr_analog_en <= in_norm || in_part || in_det;
      pwr_volt_adc_en <= in_norm;
      pwr_neutral_adc_en <= in_norm;
      pwr_curr_adc_en <= in_norm || in_part;
      pwr_digital_en <= in_norm;
      cmp_pos_en <= in_det ? det_ctrl_q[`MPMC_DET_POS_LSB+:3] : 3'h0;
      cmp_neg_en <= in_det ? det_ctrl_q[`MPMC_DET_NEG_LSB+:3] : 3'h0;
    end
  end

endmodule // mpmc_top

`default_nettype wire

// [core/mpmc_regs.vh]
// Constants of the metering power-mode controller: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name, with core/ on the include path.
`ifndef MPMC_REGS_VH
`define MPMC_REGS_VH

// Mode-select pin codes (high bit, low bit)
`define MPMC_PINS_NORMAL 2'h3
`define MPMC_PINS_PARTIAL 2'h2
`define MPMC_PINS_DETECT 2'h1
`define MPMC_PINS_IDLE 2'h0

// Register offsets (word index on the register port)
`define MPMC_REG_STATUS 10'h000
`define MPMC_REG_DET_CTRL 10'h001
`define MPMC_REG_PM_CFG 10'h014
`define MPMC_REG_RES_A 10'h015
`define MPMC_REG_RES_B 10'h016
`define MPMC_REG_RES_C 10'h017
`define MPMC_REG_THR_POS_A 10'h020
`define MPMC_REG_THR_NEG_A 10'h023

// Offsets reachable in partial measurement mode
`define MPMC_PART_LO 10'h014
`define MPMC_PART_HI 10'h01D
`define MPMC_SPEC_0 10'h000
`define MPMC_SPEC_1 10'h001
`define MPMC_SPEC_3 10'h003
`define MPMC_SPEC_7 10'h007
`define MPMC_SPEC_E 10'h00E
`define MPMC_SPEC_F 10'h00F

// Field positions
`define MPMC_DET_POS_LSB 0
`define MPMC_DET_NEG_LSB 3
`define MPMC_PM_CFG_AVG_BIT 0
`define MPMC_ST_INTERRUPT_OUT_FIRST_BIT 3
`define MPMC_ST_INTERRUPT_OUT_SECOND_BIT 4
`define MPMC_ST_DONE_BIT 5

// Reset values
`define MPMC_DET_CTRL_RST 6'h3F
`define MPMC_PM_CFG_RST 1'h0
`define MPMC_THR_RST 16'h7FFF

// Timing
`define MPMC_CLK_MHZ 100
`define MPMC_OSC_WAIT_US 100
`define MPMC_PIN_FILT_US 1

`endif

// [tb/mpmc_monitor.sv]
// Port assertions for the power-mode controller.
// Assumes binding to mpmc_top, one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module mpmc_monitor #(
  parameter integer OSC_WAIT_CYC = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] reg_rdata,
  input wire logic crystal_in,
  input wire logic [2:0] zero_cross_out,
  input wire logic [3:0] energy_pulse_out,
  input wire logic warning_output,
  input wire logic interrupt_out_first,
  input wire logic interrupt_out_second,
  input wire logic [3:0] spi_oe,
  input wire logic crystal_out,
  input wire logic osc_en,
  input wire logic pwr_volt_adc_en,
  input wire logic pwr_neutral_adc_en,
  input wire logic pwr_digital_en,
  input wire logic [2:0] cmp_pos_en,
  input wire logic [2:0] cmp_neg_en
);
  // ----
  // Wake counter, saturating so a long stay never wraps
  // ----
  logic [7:0] wake_q;
  logic [7:0] wake_d;
  wire det_w = |{cmp_pos_en, cmp_neg_en};
  assign wake_d = !osc_en ? 8'h00 : (wake_q == 8'hFF ? wake_q : wake_q + 8'h01);
  always @(posedge mclk) begin
    if (!rst_n) wake_q <= 8'h00;
    else wake_q <= wake_d;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_idle_outs_low: assert property (!osc_en |->
    {zero_cross_out, energy_pulse_out, warning_output, interrupt_out_first, interrupt_out_second} == 10'h000)
    else $error("outputs not low in idle");
  a_idle_spi_in: assert property (!osc_en |-> spi_oe == 4'h0)
    else $error("serial pins driven in idle");
  a_osc_out_gate: assert property (crystal_out == (osc_en & $past(crystal_in)))
    else $error("oscillator output wrong");
  a_normal_no_det: assert property (pwr_digital_en |-> !det_w)
    else $error("detector on in normal");
  a_low_power_off: assert property (!pwr_digital_en |-> !pwr_volt_adc_en && !pwr_neutral_adc_en)
    else $error("converters on outside normal");
  a_leave_via_idle: assert property ($fell(pwr_digital_en) |-> !osc_en)
    else $error("left normal without idle");
  a_wake_wait: assert property ($rose(pwr_digital_en) |-> wake_q >= OSC_WAIT_CYC)
    else $error("normal entered before oscillator wait");
  a_det_pins_idle: assert property (det_w |->
    {zero_cross_out, energy_pulse_out, warning_output, spi_oe} == 12'h000)
    else $error("pins active in detection");
  a_irq_hold: assert property (det_w && interrupt_out_first |=> interrupt_out_first || !osc_en)
    else $error("first interrupt dropped in detection");
  a_all_implies_any: assert property (det_w && interrupt_out_second |-> interrupt_out_first)
    else $error("second interrupt without first");
  a_det_entry_clr: assert property ($rose(det_w) |-> !interrupt_out_first && !interrupt_out_second)
    else $error("interrupts not cleared on entry");
  a_idle_read_zero: assert property (!osc_en |=> reg_rdata == 16'h0000)
    else $error("register read answered in idle");
endmodule // mpmc_monitor

bind mpmc_top mpmc_monitor #(.OSC_WAIT_CYC(OSC_WAIT_CYC)) mon_u (
  .mclk(mclk), .rst_n(rst_n), .reg_rdata(reg_rdata), .crystal_in(crystal_in),
  .zero_cross_out(zero_cross_out), .energy_pulse_out(energy_pulse_out), .warning_output(warning_output),
  .interrupt_out_first(interrupt_out_first), .interrupt_out_second(interrupt_out_second),
  .spi_oe(spi_oe), .crystal_out(crystal_out), .osc_en(osc_en), .pwr_volt_adc_en(pwr_volt_adc_en),
  .pwr_neutral_adc_en(pwr_neutral_adc_en), .pwr_digital_en(pwr_digital_en),
  .cmp_pos_en(cmp_pos_en), .cmp_neg_en(cmp_neg_en));

`default_nettype wire

// [tb/mpmc_mcu_model.sv]
// Controller model driving the two mode-select pins.
// Assumes the bench calls its tasks; pins always hold a valid level.
`timescale 1ns/100ps
`default_nettype none

module mpmc_mcu_model (
  input wire logic mclk,
  output var logic mode_select_high,
  output var logic mode_select_low
);
  // ----
  // Mode pin sequencing
  // ----
  initial begin
    mode_select_high = 1'b0;
    mode_select_low = 1'b0;
  end

  // Always via idle, held long enough to pass the pin filter
  task automatic set_mode(input logic [1:0] mode);
    @(posedge mclk);
    {mode_select_high, mode_select_low} <= 2'b00;
    repeat (10) @(posedge mclk);
    {mode_select_high, mode_select_low} <= mode;
  endtask

  // One-cycle dip from normal, shorter than the filter
  task automatic glitch;
    @(posedge mclk);
    {mode_select_high, mode_select_low} <= 2'b00;
    @(posedge mclk);
    {mode_select_high, mode_select_low} <= 2'b11;
  endtask
endmodule // mpmc_mcu_model

`default_nettype wire

// [tb/mpmc_top_test.sv]
// Self-checking bench for the power-mode controller.
// Assumes core/ on the include path; short wait and filter counts.
`timescale 1ns/100ps
`default_nettype none
`include "mpmc_regs.vh"

module mpmc_top_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mode_select_high;
  logic mode_select_low;
  logic [9:0] reg_addr = 10'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [47:0] cur_samples = 48'h0;
  logic sample_valid = 1'b0;
  logic crystal_in = 1'b0;
  logic [17:0] src = 18'h2D35A;
  wire [15:0] reg_rdata;
  wire [2:0] zero_cross_out, cmp_pos_en, cmp_neg_en;
  wire [3:0] energy_pulse_out, spi_oe, spi_o;
  wire warning_output, interrupt_out_first, interrupt_out_second, crystal_out, osc_en;
  wire pwr_analog_en, pwr_volt_adc_en, pwr_neutral_adc_en, pwr_curr_adc_en, pwr_digital_en;
  wire [18:0] pins_w = {zero_cross_out, energy_pulse_out, warning_output, interrupt_out_first,
    interrupt_out_second, spi_oe, spi_o, osc_en};
  wire [4:0] pwr_w = {pwr_analog_en, pwr_volt_adc_en, pwr_neutral_adc_en, pwr_curr_adc_en, pwr_digital_en};
  wire [1:0] irq_w = {interrupt_out_first, interrupt_out_second};
  int n_fail = 0;
  int checks_done = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) crystal_in <= ~crystal_in;

  mpmc_mcu_model mcu_u (.mclk(mclk), .mode_select_high(mode_select_high), .mode_select_low(mode_select_low));
  // Small counts keep the run short; expectations follow them
  mpmc_top #(.OSC_WAIT_CYC(4), .FILT_CYC(3), .WIN_LOG2(2)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .mode_select_high(mode_select_high), .mode_select_low(mode_select_low),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cur_samples(cur_samples), .sample_valid(sample_valid),
    .zx_src(src[17:15]), .pulse_src(src[14:11]), .warn_src(src[10]), .interrupt_out_first_src(src[9]),
    .interrupt_out_second_src(src[8]), .spi_oe_src(src[7:4]), .spi_o_src(src[3:0]), .crystal_in(crystal_in),
    .zero_cross_out(zero_cross_out), .energy_pulse_out(energy_pulse_out), .warning_output(warning_output),
    .interrupt_out_first(interrupt_out_first), .interrupt_out_second(interrupt_out_second),
    .spi_oe(spi_oe), .spi_o(spi_o), .crystal_out(crystal_out), .osc_en(osc_en),
    .pwr_analog_en(pwr_analog_en), .pwr_volt_adc_en(pwr_volt_adc_en), .pwr_neutral_adc_en(pwr_neutral_adc_en),
    .pwr_curr_adc_en(pwr_curr_adc_en), .pwr_digital_en(pwr_digital_en),
    .cmp_pos_en(cmp_pos_en), .cmp_neg_en(cmp_neg_en));

  // ----
  // Tasks
  // ----
  task automatic test_done;
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  function automatic logic at_mode(input logic [1:0] m);
    case (m)
      2'b11: return pwr_digital_en;
      2'b10: return pwr_curr_adc_en && !pwr_digital_en && osc_en;
      2'b01: return osc_en && (|{cmp_pos_en, cmp_neg_en});
      default: return !osc_en;
    endcase
  endfunction

  task automatic go(input logic [1:0] m);
    int i;
    mcu_u.set_mode(m);
    #1;
    for (i = 0; i < 40 && !at_mode(m); i++) @(posedge mclk) #1;
    if (i == 40) begin
      n_fail++;
      $display("FAIL at %0t: mode not reached", $time);
      test_done();
    end
    step(1);
  endtask

  // Sets the phase currents, then n sample pulses
  task automatic pulses(input logic [47:0] s, input int n);
    @(posedge mclk);
    cur_samples <= s;
    repeat (n) begin
      @(posedge mclk);
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
    end
    step(4);
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    step(2);
    chk(pins_w, 20'h0);
    rd(`MPMC_REG_DET_CTRL, 16'h0000);
    chk(crystal_out, 20'h0);
    go(2'b11);
    chk(pins_w, {src, 1'b1});
    chk(pwr_w, 20'h1F);
    @(posedge mclk);
    src <= ~src;
    step(2);
    chk(pins_w, {src, 1'b1});
    rd(`MPMC_REG_DET_CTRL, 16'h003F);
    for (int k = 0; k < 6; k++) wr(`MPMC_REG_THR_POS_A + 10'(k), 16'h0100);
    rd(`MPMC_REG_THR_POS_A, 16'h0100);
    wr(`MPMC_REG_PM_CFG, 16'h0000);
    pulses(48'h0030_0030_0030, 4);
    rd(`MPMC_REG_RES_A, 16'h0030);
    mcu_u.glitch();
    repeat (12) begin
      step(1);
      chk(pwr_w, 20'h1F);
    end
    go(2'b01);
    chk(pins_w, 20'h1);
    chk({cmp_pos_en, cmp_neg_en}, 20'h3F);
    rd(`MPMC_REG_DET_CTRL, 16'h0000);
    pulses(48'h0000_0000_0200, 0);
    chk(irq_w, 20'h2);
    pulses(48'h0200_0200_0200, 0);
    chk(irq_w, 20'h3);
    pulses(48'h0, 0);
    chk(irq_w, 20'h3);
    go(2'b00);
    chk(pins_w, 20'h0);
    go(2'b11);
    wr(`MPMC_REG_DET_CTRL, 16'h000C);
    go(2'b01);
    chk({cmp_pos_en, cmp_neg_en}, 20'h21);
    pulses(48'h0000_0200_0000, 0);
    chk(irq_w, 20'h0);
    pulses(48'h0000_0000_FE00, 0);
    chk(irq_w, 20'h2);
    go(2'b10);
    chk(pwr_w[3:0], 20'h2);
    chk(irq_w, 20'h0);
    wr(`MPMC_REG_PM_CFG, 16'h0001);
    rd(`MPMC_REG_PM_CFG, 16'h0001);
    rd(`MPMC_REG_DET_CTRL, 16'h000C);
    rd(`MPMC_REG_THR_POS_A, 16'h0000);
    wr(`MPMC_REG_THR_POS_A, 16'h0055);
    pulses(48'h0000_0000_FFF0, 4);
    chk(interrupt_out_first, 20'h1);
    rd(`MPMC_REG_RES_A, 16'hFFF0);
    go(2'b00);
    chk(irq_w, 20'h0);
    go(2'b11);
    rd(`MPMC_REG_THR_POS_A, 16'h0100);
    test_done();
  end
endmodule // mpmc_top_test

`default_nettype wire
